// *** verilog/spi_readout_pkg.sv ***
// What this block does
// - time read: four dummies, latch bytes low-first
// - command bits 3:2 select the slave
// - change read: six dummies, record low-first
// - reading record clears that node's change flags
// - record byte 0: node, zero, overflow flag
// - bits 11:8 flags, 15:12 latch low nibble
// - record bytes 2..5 carry ports 0..3
// - host port writes create no record
// - network output port change creates record
// - network frame beats pending host write
// - host should enable overflow interrupt
// - state read: command, address, then dummies
// - state address 0..7, increments, wraps
// - state read continues without length limit
// - one bit per node, eight per address
package spi_readout_pkg;

  localparam logic [3:0] OP_TIME       = 4'hb;
  localparam logic [3:0] OP_CHANGE     = 4'hd;
  localparam logic [3:0] OP_CONN       = 4'hf;
  localparam int         SS_LSB        = 2;
  localparam int         TIME_BYTES    = 4;
  localparam int         CHANGE_BYTES  = 6;
  localparam int         NODE_W        = 6;
  localparam int         NODES         = 64;
  localparam int         PORTS         = 4;
  localparam int         CONN_ADDR_W   = 3;
  localparam int         SCLK_HALF     = 4;
  localparam logic [7:0] DUMMY_BYTE    = 8'h00;
  localparam logic       MISO_IDLE     = 1'b0;

  typedef enum logic [1:0] {
    REQ_TIME,
    REQ_CHANGE,
    REQ_CONN
  } req_op_t;

endpackage : spi_readout_pkg

// *** verilog/spi_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  wire  miso;

  // released line reads as the pull-down level
  assign miso = miso_oe ? miso_out : spi_readout_pkg::MISO_IDLE;

  modport device (input cs_n, input sclk, input mosi, output miso_out, output miso_oe);
  modport host   (output cs_n, output sclk, output mosi, input miso);
endinterface : spi_link_if
`default_nettype wire

// *** verilog/spi_readout_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_readout_device (
  // clock and reset
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  // serial link
  spi_link_if.device                                 link,
  // configuration and status
  input  wire logic [1:0]                            slave_select_field,
  input  wire logic [31:0]                           relative_time_latch,
  input  wire logic                                  change_info_overflow_flag,
  input  wire logic [spi_readout_pkg::NODES-1:0]     conn_state,
  // network frame port update
  input  wire logic                                  frame_valid,
  input  wire logic [spi_readout_pkg::NODE_W-1:0]    frame_node,
  input  wire logic [1:0]                            frame_port,
  input  wire logic [7:0]                            frame_data,
  input  wire logic                                  frame_is_output,
  // host port data write
  input  wire logic                                  host_wr_valid,
  input  wire logic [7:0]                            host_wr_addr,
  input  wire logic [7:0]                            host_wr_data,
  output logic                                       host_wr_ack,
  // status
  output logic                                       change_pending,
  output logic [7:0]                                 port_rd_data,
  input  wire logic [7:0]                            port_rd_addr
);

  typedef struct packed {
    logic                                          sclk_q;
    logic [7:0]                                    rx;
    logic [2:0]                                    bitc;
    logic [1:0]                                    byte_idx;
    logic                                          selected;
    logic [3:0]                                    op;
    logic [47:0]                                   out_sh;
    logic [2:0]                                    remain;
    logic [7:0]                                    tx;
    logic                                          loaded;
    logic                                          miso;
    logic                                          miso_oe;
    logic [spi_readout_pkg::CONN_ADDR_W-1:0]       conn_addr;
    logic [spi_readout_pkg::NODE_W-1:0]            rec_node;
    logic [spi_readout_pkg::NODE_W-1:0]            rd_node;
    logic                                          pending;
    logic [spi_readout_pkg::NODES-1:0][3:0]        flags;
    logic [spi_readout_pkg::NODES*spi_readout_pkg::PORTS-1:0][7:0] ports;
    logic                                          wr_ack;
    logic [7:0]                                    port_rd;
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;

  function automatic logic [7:0] conn_byte(input logic [spi_readout_pkg::NODES-1:0] cs,
                                           input logic [spi_readout_pkg::CONN_ADDR_W-1:0] a);
    conn_byte = cs[{a, 3'h0} +: 8];
  endfunction : conn_byte

  logic                                    sclk_rise;
  logic                                    sclk_fall;
  logic [7:0]                              rx_byte;
  logic                                    byte_done;
  logic                                    cmd_match;
  logic [spi_readout_pkg::CONN_ADDR_W-1:0] conn_a;
  logic [7:0]                              conn_q;

  assign sclk_rise = link.sclk & ~st.sclk_q;
  assign sclk_fall = ~link.sclk & st.sclk_q;
  assign rx_byte   = {st.rx[6:0], link.mosi};
  assign byte_done = sclk_rise && (st.bitc == 3'h7);
  assign cmd_match = (rx_byte[spi_readout_pkg::SS_LSB +: 2] == slave_select_field) &&
                     (rx_byte[1:0] == 2'h0);
  // address byte picks the start, later bytes follow the counter
  assign conn_a    = (st.byte_idx == 2'h1) ? rx_byte[spi_readout_pkg::CONN_ADDR_W-1:0] : st.conn_addr;
  assign conn_q    = conn_byte(conn_state, conn_a);

  always_comb begin
    next_st        = st;
    next_st.sclk_q = link.sclk;
    next_st.wr_ack = 1'b0;
    next_st.port_rd = st.ports[port_rd_addr];

    if (link.cs_n) begin
      next_st.bitc     = 3'h0;
      next_st.byte_idx = 2'h0;
      next_st.selected = 1'b0;
      next_st.remain   = 3'h0;
      next_st.loaded   = 1'b0;
      next_st.miso_oe  = 1'b0;
      next_st.miso     = spi_readout_pkg::MISO_IDLE;
    end else begin
      if (sclk_rise) begin
        next_st.rx   = rx_byte;
        next_st.bitc = st.bitc + 3'h1;
      end
      // mode 0: shift on falling edge, never on the one right after a load
      if (sclk_fall && st.miso_oe) begin
        if (st.loaded) begin
          next_st.loaded = 1'b0;
        end else begin
          next_st.tx   = {st.tx[6:0], 1'b0};
          next_st.miso = st.tx[6];
        end
      end
      if (byte_done) begin
        if (st.byte_idx != 2'h2) begin
          next_st.byte_idx = st.byte_idx + 2'h1;
        end
        if (st.byte_idx == 2'h0) begin
          next_st.op = rx_byte[7:4];
          // command bits 1:0 must be zero and bits 3:2 must match
          if (cmd_match) begin
            next_st.selected = 1'b1;
            case (rx_byte[7:4])
              spi_readout_pkg::OP_TIME: begin
                next_st.out_sh = {16'h0000, relative_time_latch};
                next_st.remain = 3'(spi_readout_pkg::TIME_BYTES);
                next_st.tx      = relative_time_latch[7:0];
                next_st.miso    = relative_time_latch[7];
                next_st.miso_oe = 1'b1;
                next_st.loaded  = 1'b1;
              end
              spi_readout_pkg::OP_CHANGE: begin
                next_st.rd_node = st.rec_node;
                next_st.out_sh  = {st.ports[{st.rec_node, 2'h3}], st.ports[{st.rec_node, 2'h2}],
                                   st.ports[{st.rec_node, 2'h1}], st.ports[{st.rec_node, 2'h0}],
                                   relative_time_latch[3:0], st.flags[st.rec_node],
                                   change_info_overflow_flag, 1'b0, st.rec_node};
                next_st.remain  = 3'(spi_readout_pkg::CHANGE_BYTES);
                next_st.tx      = {change_info_overflow_flag, 1'b0, st.rec_node};
                next_st.miso    = change_info_overflow_flag;
                next_st.miso_oe = 1'b1;
                next_st.loaded  = 1'b1;
              end
              spi_readout_pkg::OP_CONN: begin
                next_st.remain = 3'h0;
              end
              default: begin
                next_st.selected = 1'b0;
              end
            endcase
          end else begin
            next_st.selected = 1'b0;
          end
        end else if (st.selected && st.op == spi_readout_pkg::OP_CONN) begin
          // address byte then unlimited data bytes, wrapping after 7
          next_st.tx        = conn_q;
          next_st.miso      = conn_q[7];
          next_st.miso_oe   = 1'b1;
          next_st.loaded    = 1'b1;
          next_st.conn_addr = conn_a + 3'h1;
        end else if (st.selected && st.remain != 3'h0) begin
          if (st.remain == 3'h1) begin
            next_st.miso_oe = 1'b0;
            next_st.miso    = spi_readout_pkg::MISO_IDLE;
            next_st.remain  = 3'h0;
            if (st.op == spi_readout_pkg::OP_CHANGE) begin
              next_st.flags[st.rd_node] = 4'h0;
              if (st.rd_node == st.rec_node) begin
                next_st.pending = 1'b0;
              end
            end
          end else begin
            next_st.out_sh = {8'h00, st.out_sh[47:8]};
            next_st.tx     = st.out_sh[15:8];
            next_st.miso   = st.out_sh[15];
            next_st.loaded = 1'b1;
            next_st.remain = st.remain - 3'h1;
          end
        end
      end
    end

    // network frame wins; applied after the clear so a new change is kept
    if (frame_valid) begin
      next_st.ports[{frame_node, frame_port}] = frame_data;
      if (frame_is_output && frame_data != st.ports[{frame_node, frame_port}]) begin
        next_st.flags[frame_node][frame_port] = 1'b1;
        next_st.rec_node = frame_node;
        next_st.pending  = 1'b1;
      end
    end else if (host_wr_valid) begin
      // host writes only update memory, never the record
      next_st.ports[host_wr_addr] = host_wr_data;
      next_st.wr_ack = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.miso_out = st.miso;
  assign link.miso_oe  = st.miso_oe;
  assign host_wr_ack   = st.wr_ack;
  assign change_pending = st.pending;
  assign port_rd_data  = st.port_rd;

endmodule : spi_readout_device
`default_nettype wire

// *** verilog/spi_readout_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_readout_host #(
  parameter int HALF = spi_readout_pkg::SCLK_HALF
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rstn,
  // serial link
  spi_link_if.host                      link,
  // request
  input  wire logic                     start,
  input  wire spi_readout_pkg::req_op_t op,
  input  wire logic [1:0]               slave_select_field,
  input  wire logic [7:0]               conn_addr,
  input  wire logic [7:0]               conn_len,
  // answer
  output logic                          busy,
  output logic                          rx_valid,
  output logic [7:0]                    rx_data,
  output logic                          done
);

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_XFER, H_END} hstate_t;

  typedef struct packed {
    hstate_t    fsm;
    logic [7:0] cnt;
    logic       cs_n;
    logic       sclk;
    logic       mosi;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] bitc;
    logic [8:0] idx;
    logic [8:0] total;
    logic [1:0] first_rx;
    logic       is_conn;
    logic [7:0] addr;
    logic       busy;
    logic       done;
    logic       rx_valid;
    logic [7:0] rx_data;
  } host_state_t;

  host_state_t st;
  host_state_t next_st;
  logic        tick;
  logic [3:0]  opc;
  logic [7:0]  fill_byte;

  assign tick = (st.cnt == 8'(HALF - 1));
  // address follows the command, zeros after that
  assign fill_byte = (st.is_conn && st.idx == 9'h000) ? st.addr : spi_readout_pkg::DUMMY_BYTE;

  always_comb begin
    opc = spi_readout_pkg::OP_CONN;
    case (op)
      spi_readout_pkg::REQ_TIME:   opc = spi_readout_pkg::OP_TIME;
      spi_readout_pkg::REQ_CHANGE: opc = spi_readout_pkg::OP_CHANGE;
      default:                     opc = spi_readout_pkg::OP_CONN;
    endcase
  end

  always_comb begin
    next_st          = st;
    next_st.done     = 1'b0;
    next_st.rx_valid = 1'b0;
    next_st.cnt      = (st.fsm == H_IDLE || tick) ? 8'h00 : st.cnt + 8'h01;
    case (st.fsm)
      H_IDLE: begin
        if (start) begin
          // slave number lands in bits 3:2
          next_st.tx      = {opc, slave_select_field, 2'h0};
          next_st.mosi    = opc[3];
          next_st.cs_n    = 1'b0;
          next_st.busy    = 1'b1;
          next_st.bitc    = 4'h0;
          next_st.idx     = 9'h000;
          next_st.addr    = conn_addr;
          next_st.is_conn = (op == spi_readout_pkg::REQ_CONN);
          case (op)
            spi_readout_pkg::REQ_TIME: begin
              next_st.total    = 9'(1 + spi_readout_pkg::TIME_BYTES);
              next_st.first_rx = 2'h1;
            end
            spi_readout_pkg::REQ_CHANGE: begin
              next_st.total    = 9'(1 + spi_readout_pkg::CHANGE_BYTES);
              next_st.first_rx = 2'h1;
            end
            default: begin
              next_st.total    = 9'h002 + {1'b0, conn_len};
              next_st.first_rx = 2'h2;
            end
          endcase
          next_st.fsm = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tick) begin
          next_st.fsm = H_XFER;
        end
      end
      H_XFER: begin
        if (tick) begin
          if (!st.sclk) begin
            next_st.sclk = 1'b1;
            next_st.rx   = {st.rx[6:0], link.miso};
            next_st.bitc = st.bitc + 4'h1;
          end else begin
            next_st.sclk = 1'b0;
            if (st.bitc == 4'h8) begin
              if (st.idx >= {7'h00, st.first_rx}) begin
                next_st.rx_valid = 1'b1;
                next_st.rx_data  = st.rx;
              end
              next_st.idx  = st.idx + 9'h001;
              next_st.bitc = 4'h0;
              next_st.tx   = fill_byte;
              next_st.mosi = fill_byte[7];
              if (st.idx + 9'h001 == st.total) begin
                next_st.fsm = H_END;
              end
            end else begin
              next_st.tx   = {st.tx[6:0], 1'b0};
              next_st.mosi = st.tx[6];
            end
          end
        end
      end
      H_END: begin
        if (tick) begin
          next_st.cs_n = 1'b1;
          next_st.mosi = 1'b0;
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
          next_st.fsm  = H_IDLE;
        end
      end
      default: begin
        next_st.fsm = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st      <= '0;
      st.cs_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.cs_n = st.cs_n;
  assign link.sclk = st.sclk;
  assign link.mosi = st.mosi;
  assign busy      = st.busy;
  assign rx_valid  = st.rx_valid;
  assign rx_data   = st.rx_data;
  assign done      = st.done;

endmodule : spi_readout_host
`default_nettype wire

// *** verification/spi_readout_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_readout_chk #(
  parameter logic [1:0] DEV_SS = 2'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  logic       sclk_q;
  logic [9:0] bitcnt;
  logic [7:0] cmd;
  logic       ok_ss;
  logic       is_time;
  logic       is_change;
  logic       is_conn;
  logic       ok_frame;
  logic [9:0] last_bit;

  // saturating count so endless state reads never wrap into the command byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      bitcnt <= 10'h000;
      cmd    <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        bitcnt <= 10'h000;
      end else if (sclk && !sclk_q && bitcnt != 10'h3ff) begin
        bitcnt <= bitcnt + 10'h001;
      end
      if (!cs_n && sclk && !sclk_q && bitcnt < 10'h008) begin
        cmd <= {cmd[6:0], mosi};
      end
    end
  end

  assign ok_ss     = (cmd[3:2] == DEV_SS) && (cmd[1:0] == 2'h0);
  assign is_time   = ok_ss && (cmd[7:4] == spi_readout_pkg::OP_TIME);
  assign is_change = ok_ss && (cmd[7:4] == spi_readout_pkg::OP_CHANGE);
  assign is_conn   = ok_ss && (cmd[7:4] == spi_readout_pkg::OP_CONN);
  assign ok_frame  = is_time || is_change || is_conn;
  assign last_bit  = is_time ? 10'h028 : 10'h038;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  cmd_hiz_a: assert property (!cs_n && bitcnt < 10'h008 |-> !miso_oe)
    else $error("miso driven during command byte");
  addr_hiz_a: assert property (!cs_n && is_conn && bitcnt < 10'h010 |-> !miso_oe)
    else $error("miso driven during address byte");
  foreign_quiet_a: assert property (!cs_n && bitcnt >= 10'h008 && !ok_frame |-> !miso_oe)
    else $error("miso driven for foreign command");
  data_drive_a: assert property (!cs_n && (is_time || is_change) && bitcnt > 10'h008 && bitcnt < last_bit
    |-> miso_oe)
    else $error("miso not driven in data byte");
  conn_drive_a: assert property (!cs_n && is_conn && bitcnt > 10'h010 |-> miso_oe)
    else $error("miso not driven in state byte");
  tail_off_a: assert property (!cs_n && (is_time || is_change) && bitcnt == last_bit && $fell(sclk)
    |-> ##[0:2] !miso_oe)
    else $error("miso driven past last byte");
  cs_release_a: assert property ($rose(cs_n) |-> ##[0:2] !miso_oe)
    else $error("miso driven after deselect");
  dummy_zero_a: assert property (!cs_n && sclk && bitcnt > (is_conn ? 10'h010 : 10'h008) |-> !mosi)
    else $error("dummy byte not zero");
  idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock runs outside frame");
  released_idle_a: assert property (!miso_oe |-> miso == spi_readout_pkg::MISO_IDLE)
    else $error("released miso not at idle level");
  drive_route_a: assert property (miso_oe |-> miso == miso_out)
    else $error("driven miso differs from device data");

  cover property (is_time && bitcnt == 10'h028);
  cover property (is_change && bitcnt == 10'h038);
  cover property (is_conn && bitcnt == 10'h030);
  cover property (!cs_n && bitcnt == 10'h009 && !ok_frame);
endmodule : spi_readout_chk
`default_nettype wire

// *** verification/spi_readout_commands_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_status_readout_commands_tb;
  localparam logic [47:0] REC = {8'h00, 8'h3c, 8'h00, 8'h00, 4'hf, 4'h4, 1'b1, 1'b0, 6'h05};
  logic                     clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     start = 1'b0;
  spi_readout_pkg::req_op_t op = spi_readout_pkg::REQ_TIME;
  logic [1:0]               host_ss = 2'h1;
  logic [7:0]               conn_addr = 8'h00;
  logic [7:0]               conn_len = 8'h01;
  logic                     busy;
  logic                     rx_valid;
  logic [7:0]               rx_data;
  logic                     done;
  logic [31:0]              latch = 32'h89abcdef;
  // overflow reporting on for the first change read, as the host is advised
  logic                     change_info_overflow_flag = 1'b1;
  logic [63:0]              conn_state = 64'hf7e6d5c4b3a29180;
  logic                     frame_valid = 1'b0;
  logic                     frame_is_output = 1'b0;
  logic [5:0]               frame_node = 6'h00;
  logic [1:0]               frame_port = 2'h0;
  logic [7:0]               frame_data = 8'h00;
  logic                     host_wr_valid = 1'b0;
  logic [7:0]               host_wr_addr = 8'h00;
  logic [7:0]               host_wr_data = 8'h00;
  logic                     host_wr_ack;
  logic                     change_pending;
  logic [7:0]               port_rd_addr = 8'h00;
  logic [7:0]               port_rd_data;
  logic [7:0]               rx_q[$];
  logic                     oe_seen = 1'b0;
  int                       error_cnt = 0;
  int                       check_count = 0;
  int                       cycles = 0;

  spi_link_if link ();
  spi_readout_device u_spi_readout_device (.clk(clk), .rstn(rstn), .link(link), .slave_select_field(2'h1),
    .relative_time_latch(latch), .change_info_overflow_flag(change_info_overflow_flag), .conn_state(conn_state),
    .frame_valid(frame_valid), .frame_node(frame_node), .frame_port(frame_port), .frame_data(frame_data),
    .frame_is_output(frame_is_output), .host_wr_valid(host_wr_valid), .host_wr_addr(host_wr_addr),
    .host_wr_data(host_wr_data), .host_wr_ack(host_wr_ack), .change_pending(change_pending),
    .port_rd_data(port_rd_data), .port_rd_addr(port_rd_addr));
  spi_readout_host #(.HALF(2)) u_spi_readout_host (.clk(clk), .rstn(rstn), .link(link), .start(start),
    .op(op), .slave_select_field(host_ss), .conn_addr(conn_addr), .conn_len(conn_len), .busy(busy),
    .rx_valid(rx_valid), .rx_data(rx_data), .done(done));
  spi_readout_chk #(.DEV_SS(2'h1)) u_chk (.clk(clk), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso_out(link.miso_out), .miso_oe(link.miso_oe), .miso(link.miso));

  always #2 clk = ~clk;

  // ceiling well above the seven frames this run makes
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task tick();
    @(posedge clk);
    #1;
  endtask : tick

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task run(input spi_readout_pkg::req_op_t o, input logic [1:0] s, input logic [7:0] a, input logic [7:0] n);
    rx_q = {};
    op = o;
    host_ss = s;
    conn_addr = a;
    conn_len = n;
    oe_seen = 1'b0;
    start = 1'b1;
    tick();
    start = 1'b0;
    chk("busy", 16'h1, 16'(busy));
    for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
      tick();
      if (rx_valid === 1'b1) rx_q.push_back(rx_data);
      if (link.miso_oe === 1'b1) oe_seen = 1'b1;
    end
    chk("done", 16'h1, 16'(done));
    tick();
    chk("busy after frame", 16'h0, 16'(busy));
  endtask : run

  task host_write(input logic [7:0] a, input logic [7:0] d);
    host_wr_addr = a;
    host_wr_data = d;
    host_wr_valid = 1'b1;
    for (int k = 0; k < 50 && host_wr_ack !== 1'b1; k++) tick();
    host_wr_valid = 1'b0;
    chk("write ack", 16'h1, 16'(host_wr_ack));
  endtask : host_write

  task peek(input logic [7:0] a, input logic [7:0] exp);
    port_rd_addr = a;
    tick();
    chk("port data", 16'(exp), 16'(port_rd_data));
  endtask : peek

  initial begin
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    tick();
    run(spi_readout_pkg::REQ_TIME, 2'h1, 8'h00, 8'h01);
    chk("time count", 16'h4, 16'(rx_q.size()));
    for (int i = 0; i < 4; i++) chk("time byte", 16'(latch[8*i+:8]), 16'(rx_q[i]));
    $display("test time read done");
    // every op code addressed to another slave
    for (int i = 0; i < 3; i++) begin
      run(spi_readout_pkg::req_op_t'(i), 2'h2, 8'h00, 8'h01);
      chk("foreign drive", 16'h0, 16'(oe_seen));
    end
    $display("test foreign slave done");
    host_write(8'h19, 8'h5a);
    tick();
    chk("pending after host write", 16'h0, 16'(change_pending));
    peek(8'h19, 8'h5a);
    $display("test host write done");
    frame_node = 6'h06;
    frame_port = 2'h1;
    frame_data = 8'h11;
    frame_valid = 1'b1;
    host_wr_addr = 8'h19;
    host_wr_data = 8'h22;
    host_wr_valid = 1'b1;
    repeat (3) begin
      tick();
      chk("ack under frame", 16'h0, 16'(host_wr_ack));
    end
    peek(8'h19, 8'h11);
    frame_valid = 1'b0;
    host_write(8'h19, 8'h22);
    peek(8'h19, 8'h22);
    chk("pending after input frame", 16'h0, 16'(change_pending));
    $display("test frame priority done");
    frame_node = 6'h05;
    frame_port = 2'h2;
    frame_data = 8'h3c;
    frame_is_output = 1'b1;
    frame_valid = 1'b1;
    tick();
    frame_valid = 1'b0;
    tick();
    chk("pending after frame", 16'h1, 16'(change_pending));
    run(spi_readout_pkg::REQ_CHANGE, 2'h1, 8'h00, 8'h06);
    chk("record count", 16'h6, 16'(rx_q.size()));
    for (int i = 0; i < 6; i++) chk("record byte", 16'(REC[8*i+:8]), 16'(rx_q[i]));
    chk("pending after read", 16'h0, 16'(change_pending));
    change_info_overflow_flag = 1'b0;
    run(spi_readout_pkg::REQ_CHANGE, 2'h1, 8'h00, 8'h06);
    chk("flags after read", 16'h00f0, 16'(rx_q[1]));
    chk("record low byte", 16'h0005, 16'(rx_q[0]));
    $display("test change record done");
    run(spi_readout_pkg::REQ_CONN, 2'h1, 8'h06, 8'h04);
    chk("state count", 16'h4, 16'(rx_q.size()));
    for (int i = 0; i < 4; i++) chk("state byte", 16'(conn_state[8*((6+i)%8)+:8]), 16'(rx_q[i]));
    $display("test connection state done");
    report_and_stop();
  end
endmodule : spi_status_readout_commands_tb
`default_nettype wire
